//--- fsp_pkg.sv
// Function
// - Three address bytes, low 18 bits used
// - Sample on rising edge, drive on falling
// - Clock level at select picks mode
// - Mode 3 ignores initial falling transition
// - First byte after select is command
// - One command per select, then deselect
// - Deselected: input ignored, output tristated
// - All bytes shifted most significant first
// - Master zeroes six unused address bits
// - Unknown command: ignore rest, output tristated
// - Decode set and clear latch commands
// - Decode status read and status write
// - Exactly seven command codes are valid
// - Write latch cleared after power up
// - Set latch in own select before writes
// - Latch flag set only by set command
// - Deselect clears latch after write commands
// - Clear command makes status flag zero
// - Eight-bit status byte read in full
// - Bits 0,4,5 read 0, bit 6 reads 1
// - Clear latch blocks memory writes
`default_nettype none
package fsp_pkg;
   // Widths of the serial fields.
   localparam int          BYTE_W     = 8;
   localparam int          ADDR_W     = 18;
   localparam int          ADDR_BYTES = 3;
   localparam int          MAX_EXTRA  = 4;
   // Command codes.
   localparam logic [7:0]  OP_SETWL   = 8'h06;
   localparam logic [7:0]  OP_CLRWL   = 8'h04;
   localparam logic [7:0]  OP_STRD    = 8'h05;
   localparam logic [7:0]  OP_STWR    = 8'h01;
   localparam logic [7:0]  OP_MEMRD   = 8'h03;
   localparam logic [7:0]  OP_MEMWR   = 8'h02;
   localparam logic [7:0]  OP_SLEEP   = 8'hb9;
   // Status byte layout and values.
   localparam int          ST_LATCH   = 1;
   localparam logic [7:0]  ST_RESET   = 8'h40;
   localparam logic [7:0]  ST_WR_MASK = 8'h8c;
   localparam logic [7:0]  ST_FIXED   = 8'h40;
   // Address bits kept in the first address byte; the six leading bits are zeroed.
   localparam logic [7:0]  ADDR_HI_MASK = 8'h03;
   // Host serial clock timing.
   localparam int          SYS_PERIOD_NS = 10;
   localparam int          SCK_HALF_NS   = 40;
   localparam int          SCK_HALF_CYC  =
      (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   // True for any of the seven recognised command codes.
   function automatic logic fsp_cmd_valid(input logic [7:0] c);
      return (c == OP_SETWL) || (c == OP_CLRWL) || (c == OP_STRD) ||
             (c == OP_STWR) || (c == OP_MEMRD) || (c == OP_MEMWR) ||
             (c == OP_SLEEP);
   endfunction

   // True for the memory commands that carry an address.
   function automatic logic fsp_cmd_has_addr(input logic [7:0] c);
      return (c == OP_MEMRD) || (c == OP_MEMWR);
   endfunction
endpackage
`default_nettype wire

//--- fsp_spi_if.sv
`timescale 1ns/100ps
`default_nettype none
// Serial link between the master end and the memory end.
interface fsp_spi_if;
   logic cs_n;       // Select, active low, from the master.
   logic sck;        // Serial clock from the master.
   logic mosi;       // Data toward the memory.
   logic miso;       // Data value from the memory.
   logic miso_oe;    // High while the memory drives its output.
   wire  miso_line;  // Resolved level of the shared output wire.

   // A pull-up holds the output wire high while the memory releases it.
   assign miso_line = miso_oe ? miso : 1'b1;

   modport device (input cs_n, input sck, input mosi,
                   output miso, output miso_oe);
   modport host (output cs_n, output sck, output mosi,
                 input miso_line);
endinterface
`default_nettype wire

//--- fsp_device.sv
`timescale 1ns/100ps
`default_nettype none
// Memory end: command front end clocked by the serial clock.
module fsp_device #(
   parameter int ADDR_W = fsp_pkg::ADDR_W
) (
   input  wire logic                clk_sys_in,
   input  wire logic                rst_in,
   fsp_spi_if.device                spi,
   output logic                     cmd_strobe_out,
   output logic [fsp_pkg::BYTE_W-1:0] cmd_code_out,
   output logic [ADDR_W-1:0]        mem_addr_out,
   output logic                     mem_write_ok_out,
   output logic                     write_latch_out,
   output logic [fsp_pkg::BYTE_W-1:0] status_out,
   output logic                     mode3_out
);
   import fsp_pkg::*;

   // The address shifter needs two bits and fits in three bytes.
   if (ADDR_W < 2 || ADDR_W > ADDR_BYTES * BYTE_W) begin : g_chk
      $error("ADDR_W out of range");
   end

   // Frame states, one-hot.
   typedef enum logic [3:0] {
      FR_CMD  = 4'b0001,
      FR_ADDR = 4'b0010,
      FR_DATA = 4'b0100,
      FR_IGN  = 4'b1000
   } fsp_frame_t;

   fsp_frame_t        state_q;     // Where the frame stands.
   logic [2:0]        bit_q;       // Bit within the current byte.
   logic [1:0]        abyte_q;     // Address byte count.
   logic [7:0]        shift_q;     // Incoming byte shifter.
   logic [7:0]        cmd_q;       // Received command byte.
   logic              cmd_full_q;  // All eight command bits arrived.
   logic [ADDR_W-1:0] addr_q;      // Address shifter.
   logic [7:0]        wstat_q;     // Status byte from a status write.
   logic              wstat_ok_q;  // A full status data byte arrived.
   logic              mode3_q;     // Clock was high at selection.
   logic              miso_q;      // Output bit.
   logic              oe_q;        // Output drive enable.
   logic [6:0]        tx_q;        // Remaining status bits to send.
   logic              loaded_q;    // Status byte taken for sending.
   logic              fin_tgl_q;   // Toggles at each deselect.
   logic [7:0]        fin_cmd_q;   // Command of the ended frame.
   logic              fin_ok_q;    // Ended frame held a valid command.
   logic [7:0]        fin_stat_q;  // Status data of the ended frame.
   logic              fin_sok_q;   // Status data byte was complete.
   logic [ADDR_W-1:0] fin_addr_q;  // Address of the ended frame.
   logic              fin_mode_q;  // Mode of the ended frame.
   logic              tgl_s1_q;    // Synchroniser, first stage.
   logic              tgl_s2_q;    // Synchroniser, second stage.
   logic              tgl_s3_q;    // Previous synchronised value.
   logic [7:0]        status_q;    // Status byte, latch flag inside.
   logic              strobe_q;    // Command done pulse.
   logic [7:0]        code_q;      // Last command code.
   logic [ADDR_W-1:0] maddr_q;     // Address of the last frame.
   logic              mwok_q;      // Last frame was an allowed memory write.
   logic              mode_q;      // Mode of the last frame.

   logic [7:0] shift_d;  // Byte including the bit now sampled.
   logic       byte_end; // The sampled bit completes a byte.
   logic       rd_stat;  // Frame is returning the status byte.
   logic       ev;       // A frame has ended, seen in system time.
   assign shift_d  = {shift_q[6:0], spi.mosi};
   assign byte_end = (bit_q == 3'h7);
   assign rd_stat  = (state_q == FR_DATA) && (cmd_q == OP_STRD);
   assign ev       = tgl_s2_q ^ tgl_s3_q;

   always_ff @(negedge spi.cs_n) begin
      mode3_q <= spi.sck;
   end

   // Frame sequencing on rising edges; deselect clears it.
   // Sample on rising.
   always_ff @(posedge spi.sck or posedge spi.cs_n) begin
      if (spi.cs_n) begin
         state_q    <= FR_CMD;
         bit_q      <= 3'h0;
         abyte_q    <= 2'h0;
         shift_q    <= 8'h00;
         cmd_q      <= 8'h00;
         cmd_full_q <= 1'b0;
      end else begin
         bit_q   <= bit_q + 3'h1;
         shift_q <= shift_d;
         unique case (state_q)
            FR_CMD: begin
               if (byte_end) begin
                  cmd_q      <= shift_d;
                  cmd_full_q <= 1'b1;
                  if (!fsp_cmd_valid(shift_d)) begin
                     state_q <= FR_IGN;
                  end else if (fsp_cmd_has_addr(shift_d)) begin
                     state_q <= FR_ADDR;
                  end else if (shift_d == OP_STRD ||
                               shift_d == OP_STWR) begin
                     state_q <= FR_DATA;
                  end else begin
                     state_q <= FR_IGN;
                  end
               end
            end
            // Three address bytes, then data.
            FR_ADDR: begin
               if (byte_end) begin
                  abyte_q <= abyte_q + 2'h1;
                  if (abyte_q == 2'(ADDR_BYTES - 1)) begin
                     state_q <= FR_DATA;
                  end
               end
            end
            // Data bytes until deselect.
            FR_DATA: begin
               state_q <= FR_DATA;
            end
            // Input disregarded until deselect.
            FR_IGN: begin
               state_q <= FR_IGN;
            end
         endcase
      end
   end

   // Address shifter keeps only the last address bits.
   // Leading bits drop out.
   always_ff @(posedge spi.sck or posedge spi.cs_n) begin
      if (spi.cs_n) begin
         addr_q <= '0;
      end else if (state_q == FR_ADDR) begin
         addr_q <= {addr_q[ADDR_W-2:0], spi.mosi};
      end
   end

   // First data byte of a status write is kept.
   always_ff @(posedge spi.sck or posedge spi.cs_n) begin
      if (spi.cs_n) begin
         wstat_q    <= 8'h00;
         wstat_ok_q <= 1'b0;
      end else if (state_q == FR_DATA && cmd_q == OP_STWR &&
                   byte_end && !wstat_ok_q) begin
         wstat_q    <= shift_d;
         wstat_ok_q <= 1'b1;
      end
   end

   // Status byte sent on falling edges; the status word only
   // changes a few system cycles after a deselect, so it is steady.
   always_ff @(negedge spi.sck or posedge spi.cs_n) begin
      if (spi.cs_n) begin
         miso_q   <= 1'b0;
         oe_q     <= 1'b0;
         tx_q     <= 7'h00;
         loaded_q <= 1'b0;
      end else if (rd_stat) begin
         oe_q <= 1'b1;
         if (!loaded_q) begin
            miso_q   <= status_q[7];
            tx_q     <= status_q[6:0];
            loaded_q <= 1'b1;
         end else begin
            miso_q <= tx_q[6];
            tx_q   <= {tx_q[5:0], miso_q};
         end
      end
   end
   assign spi.miso    = miso_q;
   assign spi.miso_oe = oe_q;
   // Frame result captured at the deselect edge.
   always_ff @(posedge spi.cs_n or posedge rst_in) begin
      if (rst_in) begin
         fin_tgl_q  <= 1'b0;
         fin_cmd_q  <= 8'h00;
         fin_ok_q   <= 1'b0;
         fin_stat_q <= 8'h00;
         fin_sok_q  <= 1'b0;
         fin_addr_q <= '0;
         fin_mode_q <= 1'b0;
      end else begin
         fin_tgl_q  <= ~fin_tgl_q;
         fin_cmd_q  <= cmd_q;
         fin_ok_q   <= cmd_full_q && fsp_cmd_valid(cmd_q);
         fin_stat_q <= wstat_q;
         fin_sok_q  <= wstat_ok_q;
         fin_addr_q <= addr_q;
         fin_mode_q <= mode3_q;
      end
   end
   // Frame end event crosses by toggle into system time.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         tgl_s1_q <= fin_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   // Status byte and write latch, updated when a frame ends.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         status_q <= ST_RESET;
      end else if (ev && fin_ok_q) begin
         if (fin_cmd_q == OP_SETWL) begin
            status_q[ST_LATCH] <= 1'b1;
         end else if (fin_cmd_q == OP_STWR) begin
            if (status_q[ST_LATCH] && fin_sok_q) begin
               status_q <= (fin_stat_q & ST_WR_MASK) | ST_FIXED;
            end else begin
               status_q[ST_LATCH] <= 1'b0;
            end
         end else if (fin_cmd_q == OP_CLRWL ||
                      fin_cmd_q == OP_MEMWR) begin
            status_q[ST_LATCH] <= 1'b0;
         end
      end
   end

   // Command report toward the memory core.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         strobe_q <= 1'b0;
         code_q   <= 8'h00;
         maddr_q  <= '0;
         mwok_q   <= 1'b0;
         mode_q   <= 1'b0;
      end else begin
         strobe_q <= ev && fin_ok_q;
         if (ev) begin
            code_q  <= fin_cmd_q;
            maddr_q <= fin_addr_q;
            mode_q  <= fin_mode_q;
            mwok_q  <= fin_ok_q && (fin_cmd_q == OP_MEMWR) &&
                       status_q[ST_LATCH];
         end
      end
   end

   assign cmd_strobe_out   = strobe_q;
   assign cmd_code_out     = code_q;
   assign mem_addr_out     = maddr_q;
   assign mem_write_ok_out = mwok_q;
   assign write_latch_out  = status_q[ST_LATCH];
   assign status_out       = status_q;
   assign mode3_out        = mode_q;
endmodule
`default_nettype wire

//--- fsp_host.sv
`timescale 1ns/100ps
`default_nettype none
// Master end: runs one selection per request, clock from a divider.
module fsp_host #(
   parameter int HALF_CYC = fsp_pkg::SCK_HALF_CYC
) (
   input  wire logic                   clk_sys_in,
   input  wire logic                   rst_in,
   fsp_spi_if.host                     spi,
   input  wire logic                   req_in,
   input  wire logic [fsp_pkg::BYTE_W-1:0] opcode_in,
   input  wire logic [31:0]            tx_bytes_in,
   input  wire logic [2:0]             extra_in,
   input  wire logic                   mode3_in,
   output logic                        busy_out,
   output logic                        done_out,
   output logic [fsp_pkg::BYTE_W-1:0]  rx_byte_out
);
   import fsp_pkg::*;

   // The returned bit must pass the synchroniser within a half period.
   if (HALF_CYC < 3 || HALF_CYC > 255) begin : g_chk
      $error("HALF_CYC out of range");
   end

   // Sequencer states, one-hot.
   typedef enum logic [5:0] {
      HS_IDLE  = 6'b000001,
      HS_LEAD  = 6'b000010,
      HS_LOW   = 6'b000100,
      HS_HIGH  = 6'b001000,
      HS_TRAIL = 6'b010000,
      HS_GAP   = 6'b100000
   } fsp_hstate_t;

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

   fsp_hstate_t state_q;  // Sequencer state.
   logic [7:0]  hc_q;     // Half period counter.
   logic [5:0]  bits_q;   // Bits still to send.
   logic [39:0] sh_q;     // Outgoing shifter.
   logic [7:0]  rx_q;     // Incoming shifter.
   logic        cs_n_q;   // Select output.
   logic        sck_q;    // Serial clock output.
   logic        mosi_q;   // Data output.
   logic        idle3_q;  // Idle clock level of this selection.
   logic        done_q;   // Selection finished pulse.
   logic        ms1_q;    // Synchroniser, first stage.
   logic        ms2_q;    // Synchroniser, second stage.
   logic [7:0]  first_d;  // First byte after the opcode.
   logic        half_end; // Half period elapses.

   assign half_end = (hc_q == HALF_LAST);

   always_comb begin
      first_d = tx_bytes_in[31:24];
      if (fsp_cmd_has_addr(opcode_in)) begin
         first_d = tx_bytes_in[31:24] & ADDR_HI_MASK;
      end
   end

   // Returned data passes two flip-flops.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ms1_q <= 1'b0;
         ms2_q <= 1'b0;
      end else begin
         ms1_q <= spi.miso_line;
         ms2_q <= ms1_q;
      end
   end

   // Half period counter, restarted at each state change.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || state_q == HS_IDLE || half_end) begin
         hc_q <= 8'h00;
      end else begin
         hc_q <= hc_q + 8'h01;
      end
   end

   // Selection sequencer driving select, clock and data.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_q <= HS_IDLE;
         bits_q  <= 6'h00;
         sh_q    <= 40'h0;
         rx_q    <= 8'h00;
         cs_n_q  <= 1'b1;
         sck_q   <= 1'b0;
         mosi_q  <= 1'b0;
         idle3_q <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            // Wait for a request with the clock at its idle level.
            HS_IDLE: begin
               sck_q <= mode3_in;
               if (req_in) begin
                  sh_q    <= {opcode_in, first_d, tx_bytes_in[23:0]};
                  bits_q  <= 6'(BYTE_W) * (6'h01 + 6'(
                             (extra_in > 3'(MAX_EXTRA)) ?
                             3'(MAX_EXTRA) : extra_in));
                  idle3_q <= mode3_in;
                  cs_n_q  <= 1'b0;
                  state_q <= HS_LEAD;
               end
            end
            // Select settles before the first clock edge.
            HS_LEAD: begin
               if (half_end) begin
                  sck_q   <= 1'b0;
                  mosi_q  <= sh_q[39];
                  state_q <= HS_LOW;
               end
            end
            HS_LOW: begin
               if (half_end) begin
                  sck_q   <= 1'b1;
                  state_q <= HS_HIGH;
               end
            end
            // End of high phase: take the returned bit, then fall, or go to the idle level after the last bit.
            HS_HIGH: begin
               if (half_end) begin
                  rx_q   <= {rx_q[6:0], ms2_q};
                  bits_q <= bits_q - 6'h01;
                  if (bits_q == 6'h01) begin
                     sck_q   <= idle3_q;
                     state_q <= HS_TRAIL;
                  end else begin
                     sck_q   <= 1'b0;
                     sh_q    <= {sh_q[38:0], 1'b0};
                     mosi_q  <= sh_q[38];
                     state_q <= HS_LOW;
                  end
               end
            end
            HS_TRAIL: begin
               if (half_end) begin
                  cs_n_q  <= 1'b1;
                  done_q  <= 1'b1;
                  state_q <= HS_GAP;
               end
            end
            // Select stays high a half period before the next one.
            HS_GAP: begin
               if (half_end) begin
                  state_q <= HS_IDLE;
               end
            end
         endcase
      end
   end

   assign spi.cs_n    = cs_n_q;
   assign spi.sck     = sck_q;
   assign spi.mosi    = mosi_q;
   assign busy_out    = (state_q != HS_IDLE);
   assign done_out    = done_q;
   assign rx_byte_out = rx_q;
endmodule
`default_nettype wire

//--- fsp_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the serial link between both ends, sampled by the system clock.
module fsp_link_assertions (
   input wire logic clk_sys_in, // System clock.
   input wire logic rst_in,     // Synchronous reset, active high.
   input wire logic cs_n,       // Select, active low.
   input wire logic sck,        // Serial clock.
   input wire logic mosi,       // Data toward the memory.
   input wire logic miso,       // Data value from the memory.
   input wire logic miso_oe     // Memory output enable.
);
   logic       sck_q;  // Serial clock one system cycle ago.
   logic [7:0] rise_q; // Rising serial clock edges seen in this frame.

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // Counts rising clock edges while selected; clears between frames.
   always_ff @(posedge clk_sys_in) begin
      sck_q <= sck;
      if (rst_in || cs_n) begin
         rise_q <= 8'h00;
      end else if (sck && !sck_q) begin
         rise_q <= rise_q + 8'h01;
      end
   end

   // Clock holds its level for a lead phase after select falls.
   sequence s_lead; $stable(sck)[*4]; endsequence
   // Clock stays high for a full half period.
   sequence s_high; sck[*4]; endsequence

   property p_lead; $fell(cs_n) |-> s_lead; endproperty
   property p_high; $rose(sck) && !cs_n |-> s_high; endproperty
   property p_mosi_hold;
      $rose(sck) && !cs_n |=> $stable(mosi)[*3];
   endproperty
   property p_out_fall;
      !cs_n && miso_oe && ($changed(miso) || $rose(miso_oe)) |-> !sck;
   endproperty
   property p_idle_quiet; cs_n && $past(cs_n) |-> !miso_oe; endproperty
   property p_oe_drop; $fell(miso_oe) |-> cs_n; endproperty
   property p_gap; $rose(cs_n) |-> cs_n[*4]; endproperty
   property p_bytes;
      $rose(cs_n) |-> rise_q[2:0] == 3'h0 && rise_q != 8'h00;
   endproperty
   property p_oe_cmd; $rose(miso_oe) |-> rise_q == 8'h08; endproperty

   a_lead: assert property (p_lead)
      else $error("clock moved during lead phase");
   a_high: assert property (p_high)
      else $error("clock high phase too short");
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("data in changed while clock high");
   a_out_fall: assert property (p_out_fall)
      else $error("data out changed while clock high");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("output driven while deselected");
   a_oe_drop: assert property (p_oe_drop)
      else $error("output released inside a frame");
   a_gap: assert property (p_gap)
      else $error("deselect gap too short");
   a_bytes: assert property (p_bytes)
      else $error("frame not whole bytes");
   a_oe_cmd: assert property (p_oe_cmd)
      else $error("output began before command byte ended");
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Runs frames from the master end and checks the memory end's reports.
module tb_top;
   import fsp_pkg::*;
   // One frame and the state expected after it.
   typedef struct packed {
      logic [7:0]  op;  // Command byte.
      logic [31:0] tx;  // Following bytes, first in the top byte.
      logic [2:0]  n;   // Count of following bytes.
      logic        m3;  // Idle clock high.
      logic        wl;  // Expected latch flag.
      logic [7:0]  st;  // Expected status byte.
      logic        stb; // Expected command strobe.
   } fsp_row_t;
   logic        clk_sys_in, rst_in, req_in, mode3_in, busy_out, done_out;
   logic [7:0]  opcode_in, rx_byte_out, cmd_code_out, status_out;
   logic [31:0] tx_bytes_in;
   logic [2:0]  extra_in;
   logic [17:0] mem_addr_out;
   logic        cmd_strobe_out, mem_write_ok_out, write_latch_out, mode3_out;
   int          num_errors, cmp_count, strobes, dones;
   logic [7:0]  prev_st; // Status expected before the frame.
   logic        prev_wl; // Latch expected before the frame.
   fsp_row_t rows [19] = '{
      '{8'h05, 32'h0, 3'h1, 1'b0, 1'b0, 8'h40, 1'b1},
      '{8'h01, 32'hff000000, 3'h1, 1'b0, 1'b0, 8'h40, 1'b1},
      '{8'h06, 32'h0, 3'h0, 1'b1, 1'b1, 8'h42, 1'b1},
      '{8'h05, 32'h0, 3'h1, 1'b1, 1'b1, 8'h42, 1'b1},
      '{8'h01, 32'hff000000, 3'h1, 1'b0, 1'b0, 8'hcc, 1'b1},
      '{8'h05, 32'h0, 3'h1, 1'b0, 1'b0, 8'hcc, 1'b1},
      '{8'h06, 32'h0, 3'h0, 1'b0, 1'b1, 8'hce, 1'b1},
      '{8'h01, 32'h02000000, 3'h1, 1'b1, 1'b0, 8'h40, 1'b1},
      '{8'h06, 32'h0, 3'h0, 1'b0, 1'b1, 8'h42, 1'b1},
      '{8'h04, 32'h0, 3'h0, 1'b1, 1'b0, 8'h40, 1'b1},
      '{8'h06, 32'h0, 3'h0, 1'b0, 1'b1, 8'h42, 1'b1},
      '{8'h02, 32'h02a55a00, 3'h3, 1'b0, 1'b0, 8'h40, 1'b1},
      '{8'h02, 32'h03ffff00, 3'h3, 1'b1, 1'b0, 8'h40, 1'b1},
      '{8'h03, 32'h01234500, 3'h3, 1'b0, 1'b0, 8'h40, 1'b1},
      '{8'hb9, 32'h0, 3'h0, 1'b0, 1'b0, 8'h40, 1'b1},
      '{8'hff, 32'h0, 3'h0, 1'b0, 1'b0, 8'h40, 1'b0},
      '{8'h00, 32'h0, 3'h1, 1'b1, 1'b0, 8'h40, 1'b0},
      '{8'h06, 32'h0, 3'h0, 1'b0, 1'b1, 8'h42, 1'b1},
      '{8'h5a, 32'h0, 3'h1, 1'b0, 1'b1, 8'h42, 1'b0}};

   fsp_spi_if fsp_spi_if_inst ();
   fsp_host fsp_host_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .spi(fsp_spi_if_inst), .req_in(req_in), .opcode_in(opcode_in),
      .tx_bytes_in(tx_bytes_in), .extra_in(extra_in), .mode3_in(mode3_in),
      .busy_out(busy_out), .done_out(done_out), .rx_byte_out(rx_byte_out));
   fsp_device fsp_device_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .spi(fsp_spi_if_inst), .cmd_strobe_out(cmd_strobe_out),
      .cmd_code_out(cmd_code_out), .mem_addr_out(mem_addr_out),
      .mem_write_ok_out(mem_write_ok_out),
      .write_latch_out(write_latch_out), .status_out(status_out),
      .mode3_out(mode3_out));
   fsp_link_assertions fsp_link_assertions_inst (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .cs_n(fsp_spi_if_inst.cs_n),
      .sck(fsp_spi_if_inst.sck), .mosi(fsp_spi_if_inst.mosi),
      .miso(fsp_spi_if_inst.miso), .miso_oe(fsp_spi_if_inst.miso_oe));

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic give_verdict();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Waits a bounded time for busy to reach a level.
   task automatic wait_busy(input logic lvl);
      int i;
      i = 0;
      while (busy_out !== lvl) begin
         @(posedge clk_sys_in);
         i++;
         if (i > 2000) begin
            num_errors++;
            give_verdict();
         end
      end
   endtask
   // Runs one frame; a poke repeats the request while busy.
   task automatic xfer(input fsp_row_t r, input logic poke);
      int s0;
      int d0;
      s0 = strobes;
      d0 = dones;
      @(posedge clk_sys_in);
      mode3_in    <= r.m3;
      opcode_in   <= r.op;
      tx_bytes_in <= r.tx;
      extra_in    <= r.n;
      repeat (3) @(posedge clk_sys_in);
      req_in <= 1'b1;
      @(posedge clk_sys_in);
      req_in <= 1'b0;
      @(posedge clk_sys_in);
      if (poke) begin
         repeat (8) @(posedge clk_sys_in);
         req_in <= 1'b1;
         @(posedge clk_sys_in);
         req_in <= 1'b0;
      end
      wait_busy(1'b0);
      repeat (10) @(posedge clk_sys_in);
      chk(strobes - s0, r.stb);
      chk(dones - d0, 32'h1);
      chk(write_latch_out, r.wl);
      chk(status_out, r.st);
      if (r.stb) begin
         chk(cmd_code_out, r.op);
         chk(mode3_out, r.m3);
      end
      if (r.op == OP_STRD) begin
         chk(rx_byte_out, prev_st);
      end else begin
         chk(rx_byte_out, 8'hff);
      end
      if (r.op == OP_MEMWR || r.op == OP_MEMRD) begin
         chk(mem_addr_out, {r.tx[25:24], r.tx[23:8]});
         chk(mem_write_ok_out, r.op == OP_MEMWR && prev_wl);
      end
      prev_st = r.st;
      prev_wl = r.wl;
   endtask

   // System clock at 100 MHz.
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // Counts command strobes and finished selections.
   always @(posedge clk_sys_in) begin
      if (cmd_strobe_out === 1'b1) begin
         strobes <= strobes + 1;
      end
      if (done_out === 1'b1) begin
         dones <= dones + 1;
      end
   end
   // Main sequence: table rows, a refused request, then a second reset.
   initial begin
      rst_in = 1'b1;
      req_in = 1'b0;
      mode3_in = 1'b0;
      opcode_in = 8'h00;
      tx_bytes_in = 32'h0;
      extra_in = 3'h0;
      num_errors = 0;
      cmp_count = 0;
      strobes = 0;
      dones = 0;
      prev_st = 8'h40;
      prev_wl = 1'b0;
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 19; i++) begin
         xfer(rows[i], 1'b0);
      end
      xfer('{8'h04, 32'h0, 3'h0, 1'b0, 1'b0, 8'h40, 1'b1}, 1'b1);
      xfer('{8'h06, 32'h0, 3'h0, 1'b1, 1'b1, 8'h42, 1'b1}, 1'b0);
      rst_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      chk(status_out, 8'h40);
      chk(write_latch_out, 1'b0);
      prev_st = 8'h40;
      prev_wl = 1'b0;
      xfer('{8'h05, 32'h0, 3'h1, 1'b0, 1'b0, 8'h40, 1'b1}, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
